// File: uap_checker.sv
// Purpose: port-level assertions for the serial port register block
// Assumes: sees only the top ports; one clock domain
// Notes:   bound from the bench top file
`timescale 1ns/10ps
`default_nettype none
module uap_checker
  import uap_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic              aclk,
  input wire logic              aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic [3:0]        s_axi_wstrb,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              serial_rx_line,
  input wire logic              serial_tx_line,
  input wire logic              irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_aw_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready held longer than one cycle");
  chk_read_answer: assert property
    (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer missing after address taken");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
  chk_r_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  chk_write_resp: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
  chk_reset_state: assert property ($rose(aresetn) |-> serial_tx_line && !irq)
    else $error("line or interrupt not idle after reset");
endmodule : uap_checker
`default_nettype wire

// File: uap_peer.sv
// Purpose: remote serial node facing the block's serial lines
// Assumes: no parity, one stop bit, bit time given in clock cycles
// Notes:   idle line is high, as a real receiver pull-up would leave it
`timescale 1ns/10ps
`default_nettype none
module uap_peer (
  input  wire logic        clk,
  input  wire logic        tx,
  input  wire logic [15:0] bit_cyc,
  input  wire logic [3:0]  nbits,
  output logic             rx,
  output logic [7:0]       got,
  output logic [7:0]       got_n
);
  logic [7:0] sh;
  initial begin
    rx = 1'b1;
    got = 8'h00;
    got_n = 8'h00;
  end
  // samples mid-bit, lsb first; bits above nbits read zero
  always begin
    @(negedge tx);
    sh = 8'h00;
    repeat (bit_cyc / 2) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      repeat (bit_cyc) @(posedge clk);
      sh[i] = tx;
    end
    repeat (bit_cyc) @(posedge clk);
    got <= sh;
    got_n <= got_n + 8'h01;
  end
  task automatic send(input logic [7:0] v, input logic stop);
    rx <= 1'b0;
    repeat (bit_cyc) @(posedge clk);
    for (int i = 0; i < nbits; i++) begin
      rx <= v[i];
      repeat (bit_cyc) @(posedge clk);
    end
    rx <= stop;
    repeat (bit_cyc) @(posedge clk);
    rx <= 1'b1;
    repeat (bit_cyc) @(posedge clk);
  endtask : send
  task automatic low(input int n);
    rx <= 1'b0;
    repeat (n) @(posedge clk);
    rx <= 1'b1;
    repeat (8) @(posedge clk);
  endtask : low
endmodule : uap_peer
`default_nettype wire

// File: uap_pkg.sv
// Purpose: shared constants and types for the serial port register block
// Assumes: 32-bit AXI4-Lite register access, one aligned word per register
// Notes:   register bytes sit in data bits 7:0, upper bits read zero
package uap_pkg;

  // byte offsets of the registers
  localparam logic [7:0] OFS_BRLO  = 8'h00;
  localparam logic [7:0] OFS_BRHI  = 8'h04;
  localparam logic [7:0] OFS_MCTL  = 8'h08;
  localparam logic [7:0] OFS_STAT  = 8'h0C;
  localparam logic [7:0] OFS_RXBUF = 8'h10;
  localparam logic [7:0] OFS_TXBUF = 8'h14;
  localparam logic [7:0] OFS_IRTX  = 8'h18;
  localparam logic [7:0] OFS_IRRX  = 8'h1C;
  localparam logic [7:0] OFS_ABCTL = 8'h20;
  localparam logic [7:0] OFS_CTL   = 8'h24;
  localparam logic [7:0] OFS_IFG   = 8'h28;
  localparam logic [7:0] OFS_IE    = 8'h2C;

  // line status bit positions
  localparam int ST_BUSY   = 0;
  localparam int ST_ADID   = 1;
  localparam int ST_RXERR  = 2;
  localparam int ST_BRK    = 3;
  localparam int ST_PE     = 4;
  localparam int ST_OE     = 5;
  localparam int ST_FE     = 6;
  localparam int ST_LISTEN = 7;
  // flags among bits 6:1 that a receive data read clears; break survives
  localparam logic [6:1] ST_RDCLR = 6'h3B;

  // interrupt flag positions
  localparam int IF_RX = 0;
  localparam int IF_TX = 1;

  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [1:0] RST_IFG  = 2'h2;
  localparam logic       RST_TXD  = 1'b1;

  // line timing in bit times, and the shift that divides the synch count by 8
  localparam int BRK_MIN_BITS = 11;
  localparam int BRK_TO_BITS  = 22;
  localparam int IDLE_BITS    = 10;
  localparam int SYN_SHIFT    = 3;

  localparam logic [1:0] MP_IDLE = 2'h1;
  localparam logic [1:0] MP_ADDR = 2'h2;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  typedef enum logic [2:0] {
    PH_IDLE  = 3'b000,
    PH_START = 3'b001,
    PH_DATA  = 3'b010,
    PH_ADDR  = 3'b011,
    PH_PAR   = 3'b100,
    PH_STOP  = 3'b101
  } uap_ph_t;

  typedef enum logic [1:0] {
    AB_RUN = 2'b00,
    AB_BRK = 2'b01,
    AB_DLM = 2'b10,
    AB_SYN = 2'b11
  } uap_ab_t;

  typedef struct packed {
    logic       tx_addr;
    logic [1:0] mp_mode;
    logic       par_even;
    logic       par_en;
    logic       seven;
  } uap_ctl_t;

  typedef struct packed {
    logic [1:0] rsv_hi;
    logic [1:0] delimiter_len;
    logic       synch_timeout_err;
    logic       break_timeout_err;
    logic       rsv_lo;
    logic       autobaud_en;
  } uap_abc_t;

endpackage : uap_pkg

// File: uap_top.sv
// Purpose: asynchronous serial port with registers on AXI4-Lite
// Assumes: serial_rx_line is synchronous to aclk; one stop bit, 7 or 8 data bits, optional address and parity bits
// Notes:   modulation and infrared registers are storage only
`timescale 1ns/10ps
`default_nettype none
module uap_top
  import uap_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              serial_rx_line,
  output logic                   serial_tx_line,
  output logic                   irq
);

  if (ADDR_W < 8) begin : g_chk
    $error("uap_top: ADDR_W must be at least 8");
  end

  localparam int LC_W = 21;

  logic [7:0] brlo_r, brhi_r, mctl_r, irtx_r, irrx_r;
  logic [7:0] rxbuf_r, txbuf_r, wdat_r;
  uap_ctl_t   ctl_r;
  uap_abc_t   abc_r;
  logic [6:1] st_r, st_ev;
  logic       listen_r, tx_full_r, idle_pend_r, rx_prev_r;
  logic [1:0] ifg_r, ie_r, bresp_r, rresp_r;
  logic       awready_r, wready_r, aw_got_r, w_got_r, wstrb_r;
  logic       bvalid_r, arready_r, rvalid_r, irq_r;
  logic [31:0] rdata_r;
  logic [ADDR_W-1:0] awaddr_r;
  uap_ph_t    rx_ph_r, tx_ph_r, tx_q;
  uap_ab_t    ab_r;
  logic [15:0] rx_cnt_r, tx_cnt_r;
  logic [2:0] rx_n_r, tx_n_r;
  logic [7:0] rx_sh_r, tx_sh_r;
  logic       rx_par_r, rx_adb_r, rx_pe_r, tx_par_r, txd_r;
  logic [LC_W-1:0] lc_r;
  logic [18:0] syn_cnt_r;
  logic [1:0]  syn_e_r;

  // bus decode
  wire [5:0] wa      = awaddr_r[7:2];
  wire [5:0] ra      = s_axi_araddr[7:2];
  wire       wa_hi0  = ((awaddr_r >> 8) == '0);
  wire       ra_hi0  = ((s_axi_araddr >> 8) == '0);
  wire       do_wr   = aw_got_r & w_got_r & ~bvalid_r;
  wire       wr_ok   = do_wr & wstrb_r & wa_hi0;
  wire       ar_hs   = s_axi_arvalid & arready_r;
  wire       wr_brlo = wr_ok & (wa == OFS_BRLO[7:2]);
  wire       wr_brhi = wr_ok & (wa == OFS_BRHI[7:2]);
  wire       wr_mctl = wr_ok & (wa == OFS_MCTL[7:2]);
  wire       wr_st   = wr_ok & (wa == OFS_STAT[7:2]);
  wire       wr_tx   = wr_ok & (wa == OFS_TXBUF[7:2]);
  wire       wr_irtx = wr_ok & (wa == OFS_IRTX[7:2]);
  wire       wr_irrx = wr_ok & (wa == OFS_IRRX[7:2]);
  wire       wr_abc  = wr_ok & (wa == OFS_ABCTL[7:2]);
  wire       wr_ctl  = wr_ok & (wa == OFS_CTL[7:2]);
  wire       wr_ifg  = wr_ok & (wa == OFS_IFG[7:2]);
  wire       wr_ie   = wr_ok & (wa == OFS_IE[7:2]);
  wire       wa_map  = wa_hi0 & (wa <= OFS_IE[7:2]);
  wire       ra_map  = ra_hi0 & (ra <= OFS_IE[7:2]);
  wire       rd_rx   = ar_hs & ra_hi0 & (ra == OFS_RXBUF[7:2]);

  // line and timing
  wire        rx_line = listen_r ? txd_r : serial_rx_line;
  wire        rx_fall = rx_prev_r & ~rx_line;
  wire [15:0] div_w   = {brhi_r, brlo_r};
  wire [15:0] div_eff = (div_w == 16'h0000) ? 16'h0001 : div_w;
  wire [15:0] div_m1  = div_eff - 16'h0001;
  wire [2:0]  dlm_mul = {1'b0, abc_r.delimiter_len} + 3'h1;
  wire [LC_W-1:0] brk_min  = LC_W'(div_eff) * LC_W'(BRK_MIN_BITS);
  wire [LC_W-1:0] brk_to   = LC_W'(div_eff) * LC_W'(BRK_TO_BITS);
  wire [LC_W-1:0] idle_lim = LC_W'(div_eff) * LC_W'(IDLE_BITS);
  wire [LC_W-1:0] dlm_lim  = LC_W'(div_eff) * LC_W'(dlm_mul);
  wire       mp_addr = (ctl_r.mp_mode == MP_ADDR);
  wire       mp_idle = (ctl_r.mp_mode == MP_IDLE);
  wire [2:0] n_last  = ctl_r.seven ? 3'h6 : 3'h7;
  wire uap_ph_t ph_adr_nx = ctl_r.par_en ? PH_PAR : PH_STOP;
  wire uap_ph_t ph_dat_nx = mp_addr ? PH_ADDR : ph_adr_nx;

  // events
  wire rx_tick  = (rx_cnt_r == 16'h0000);
  wire tx_tick  = (tx_cnt_r == 16'h0000);
  wire rx_done  = (rx_ph_r == PH_STOP) & rx_tick;
  wire brk_ev   = ~rx_line & (lc_r == brk_min);
  wire ab_on    = abc_r.autobaud_en;
  wire rx_abort = brk_ev & ab_on & (ab_r == AB_RUN);
  wire btoe_ev  = (ab_r == AB_BRK) & ~rx_line & (lc_r == brk_to);
  wire stoe_ev  = (ab_r == AB_SYN) & (&syn_cnt_r);
  wire syn_done = (ab_r == AB_SYN) & rx_fall & (syn_e_r == 2'h3);
  wire fe_ev    = rx_done & ~rx_line;
  wire pe_ev    = rx_done & ctl_r.par_en & rx_pe_r;
  wire oe_ev    = rx_done & ifg_r[IF_RX];
  wire adid_ev  = rx_done & (mp_addr ? rx_adb_r : mp_idle & idle_pend_r);
  wire tx_load  = (tx_ph_r == PH_IDLE) & tx_full_r;
  wire busy     = (rx_ph_r != PH_IDLE) | (tx_ph_r != PH_IDLE) | tx_full_r;
  wire [7:0] rx_char = ctl_r.seven ? {1'b0, rx_sh_r[7:1]} : rx_sh_r;

  assign st_ev = {fe_ev, oe_ev, pe_ev, brk_ev,
                  fe_ev | pe_ev | oe_ev, adid_ev};

  // read mux
  wire [7:0] st_rd = {listen_r, st_r, busy};
  wire [7:0] rd_val =
      ({8{ra == OFS_BRLO[7:2]}}  & brlo_r)
    | ({8{ra == OFS_BRHI[7:2]}}  & brhi_r)
    | ({8{ra == OFS_MCTL[7:2]}}  & mctl_r)
    | ({8{ra == OFS_STAT[7:2]}}  & st_rd)
    | ({8{ra == OFS_RXBUF[7:2]}} & rxbuf_r)
    | ({8{ra == OFS_TXBUF[7:2]}} & txbuf_r)
    | ({8{ra == OFS_IRTX[7:2]}}  & irtx_r)
    | ({8{ra == OFS_IRRX[7:2]}}  & irrx_r)
    | ({8{ra == OFS_ABCTL[7:2]}} & {2'h0, abc_r[5:2], 1'b0, abc_r[0]})
    | ({8{ra == OFS_CTL[7:2]}}   & {2'h0, ctl_r})
    | ({8{ra == OFS_IFG[7:2]}}   & {6'h00, ifg_r})
    | ({8{ra == OFS_IE[7:2]}}    & {6'h00, ie_r});

  // axi4-lite write channel; address and data may come in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OK;
      awaddr_r  <= '0;
      wdat_r    <= RST_BYTE;
      wstrb_r   <= 1'b0;
    end else begin
      awready_r <= ~awready_r & s_axi_awvalid & ~aw_got_r;
      wready_r  <= ~wready_r & s_axi_wvalid & ~w_got_r;
      if (s_axi_awvalid & awready_r) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (do_wr) begin
        aw_got_r <= 1'b0;
      end
      if (s_axi_wvalid & wready_r) begin
        w_got_r <= 1'b1;
        wdat_r  <= s_axi_wdata[7:0];
        wstrb_r <= s_axi_wstrb[0];
      end else if (do_wr) begin
        w_got_r <= 1'b0;
      end
      if (do_wr) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wa_map ? RESP_OK : RESP_ERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // axi4-lite read channel; rdata is registered at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OK;
      rdata_r   <= 32'h0000_0000;
    end else begin
      arready_r <= ~arready_r & s_axi_arvalid & ~rvalid_r;
      if (ar_hs) begin
        rvalid_r <= 1'b1;
        rdata_r  <= {24'h00_0000, ra_map ? rd_val : 8'h00};
        rresp_r  <= ra_map ? RESP_OK : RESP_ERR;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // plain software registers; auto-baud may overwrite the divider
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      brlo_r   <= RST_BYTE;
      brhi_r   <= RST_BYTE;
      mctl_r   <= RST_BYTE;
      irtx_r   <= RST_BYTE;
      irrx_r   <= RST_BYTE;
      ctl_r    <= '0;
      ie_r     <= 2'h0;
      listen_r <= 1'b0;
    end else begin
      if (wr_brlo) brlo_r <= wdat_r;
      else if (syn_done) brlo_r <= syn_cnt_r[10:3];
      if (wr_brhi) brhi_r <= wdat_r;
      else if (syn_done) brhi_r <= syn_cnt_r[18:11];
      if (wr_mctl) mctl_r <= wdat_r;
      if (wr_irtx) irtx_r <= wdat_r;
      if (wr_irrx) irrx_r <= wdat_r;
      if (wr_ctl) ctl_r <= wdat_r[5:0];
      if (wr_ie) ie_r <= wdat_r[1:0];
      if (wr_st) listen_r <= wdat_r[ST_LISTEN];
    end
  end

  // auto-baud control: error flags set by hardware win over a write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      abc_r <= '0;
    end else begin
      if (wr_abc) begin
        abc_r.autobaud_en   <= wdat_r[0];
        abc_r.delimiter_len <= wdat_r[5:4];
      end
      abc_r.synch_timeout_err <= stoe_ev |
        (wr_abc ? wdat_r[3] : abc_r.synch_timeout_err);
      abc_r.break_timeout_err <= btoe_ev |
        (wr_abc ? wdat_r[2] : abc_r.break_timeout_err);
    end
  end

  // sticky line status flags; an event in the clearing cycle survives
  for (genvar i = 1; i < 7; i++) begin : g_st
    always_ff @(posedge aclk) begin
      if (!aresetn) st_r[i] <= 1'b0;
      else st_r[i] <= st_ev[i] | (wr_st ? wdat_r[i]
                      : st_r[i] & ~(rd_rx & ST_RDCLR[i]));
    end
  end

  // interrupt flags and output
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ifg_r <= RST_IFG;
      irq_r <= 1'b0;
    end else begin
      ifg_r[IF_RX] <= rx_done | (ifg_r[IF_RX] & ~rd_rx
                      & ~(wr_ifg & wdat_r[IF_RX]));
      ifg_r[IF_TX] <= tx_load | (ifg_r[IF_TX] & ~wr_tx
                      & ~(wr_ifg & wdat_r[IF_TX]));
      irq_r <= |(ifg_r & ie_r);
    end
  end

  // receive and transmit buffers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rxbuf_r   <= RST_BYTE;
      txbuf_r   <= RST_BYTE;
      tx_full_r <= 1'b0;
    end else begin
      if (rx_done) rxbuf_r <= rx_char;
      if (wr_tx) txbuf_r <= {wdat_r[7] & ~ctl_r.seven, wdat_r[6:0]};
      tx_full_r <= wr_tx | (tx_full_r & ~tx_load);
    end
  end

  // line activity counter: cycles since the last level change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_prev_r   <= RST_TXD;
      lc_r        <= '0;
      idle_pend_r <= 1'b0;
    end else begin
      rx_prev_r <= rx_line;
      if (rx_line != rx_prev_r) lc_r <= '0;
      else if (~&lc_r) lc_r <= lc_r + LC_W'(1);
      idle_pend_r <= (rx_line & (lc_r == idle_lim))
                     | (idle_pend_r & ~rx_done);
    end
  end

  // auto-baud: break, delimiter, then five falling edges span 8 bits
  always_ff @(posedge aclk) begin
    if (!aresetn || !ab_on) begin
      ab_r      <= AB_RUN;
      syn_cnt_r <= '0;
      syn_e_r   <= 2'h0;
    end else begin
      unique case (ab_r)
        AB_RUN: if (brk_ev) ab_r <= AB_BRK;
        AB_BRK: if (rx_line) ab_r <= AB_DLM;
        AB_DLM: begin
          syn_cnt_r <= 19'h00001; // the edge that ends the field counts too
          syn_e_r   <= 2'h0;
          if (rx_fall) ab_r <= (lc_r >= dlm_lim) ? AB_SYN : AB_RUN;
        end
        AB_SYN: begin
          syn_cnt_r <= syn_cnt_r + 19'h00001;
          if (rx_fall) syn_e_r <= syn_e_r + 2'h1;
          if (syn_done || stoe_ev) ab_r <= AB_RUN;
        end
      endcase
    end
  end

  // receiver sequencing; samples mid-bit
  always_ff @(posedge aclk) begin
    if (!aresetn || rx_abort) begin
      rx_ph_r  <= PH_IDLE;
      rx_cnt_r <= 16'h0000;
    end else if (rx_ph_r == PH_IDLE) begin
      if (rx_fall && ab_r == AB_RUN) begin
        rx_ph_r  <= PH_START;
        rx_cnt_r <= {1'b0, div_eff[15:1]};
      end
    end else if (!rx_tick) begin
      rx_cnt_r <= rx_cnt_r - 16'h0001;
    end else begin
      rx_cnt_r <= div_m1;
      unique case (rx_ph_r)
        PH_START: rx_ph_r <= rx_line ? PH_IDLE : PH_DATA;
        PH_DATA:  if (rx_n_r == n_last) rx_ph_r <= ph_dat_nx;
        PH_ADDR:  rx_ph_r <= ph_adr_nx;
        PH_PAR:   rx_ph_r <= PH_STOP;
        default:  rx_ph_r <= PH_IDLE;
      endcase
    end
  end

  // receiver data path
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_sh_r  <= RST_BYTE;
      rx_n_r   <= 3'h0;
      rx_par_r <= 1'b0;
      rx_adb_r <= 1'b0;
      rx_pe_r  <= 1'b0;
    end else if (rx_tick && rx_ph_r != PH_IDLE) begin
      if (rx_ph_r == PH_START) begin
        rx_n_r   <= 3'h0;
        rx_par_r <= ~ctl_r.par_even;
        rx_adb_r <= 1'b0;
        rx_pe_r  <= 1'b0;
      end
      if (rx_ph_r == PH_DATA) begin
        rx_sh_r  <= {rx_line, rx_sh_r[7:1]};
        rx_n_r   <= rx_n_r + 3'h1;
        rx_par_r <= rx_par_r ^ rx_line;
      end
      if (rx_ph_r == PH_ADDR) begin
        rx_adb_r <= rx_line;
        rx_par_r <= rx_par_r ^ rx_line;
      end
      if (rx_ph_r == PH_PAR) rx_pe_r <= rx_line ^ rx_par_r;
    end
  end

  // transmitter: next phase after each bit time
  assign tx_q = (tx_ph_r == PH_START) ? PH_DATA
              : (tx_ph_r == PH_DATA) ? ((tx_n_r != n_last) ? PH_DATA
                                        : ph_dat_nx)
              : (tx_ph_r == PH_ADDR) ? ph_adr_nx
              : (tx_ph_r == PH_PAR)  ? PH_STOP : PH_IDLE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_ph_r  <= PH_IDLE;
      tx_cnt_r <= 16'h0000;
      txd_r    <= RST_TXD;
      tx_sh_r  <= RST_BYTE;
      tx_n_r   <= 3'h0;
      tx_par_r <= 1'b0;
    end else if (tx_load) begin
      tx_ph_r  <= PH_START;
      tx_cnt_r <= div_m1;
      txd_r    <= 1'b0;
      tx_sh_r  <= txbuf_r;
      tx_par_r <= ~ctl_r.par_even;
    end else if (tx_ph_r != PH_IDLE) begin
      if (!tx_tick) begin
        tx_cnt_r <= tx_cnt_r - 16'h0001;
      end else begin
        tx_cnt_r <= div_m1;
        tx_ph_r  <= tx_q;
        if (tx_q == PH_DATA) begin
          txd_r    <= tx_sh_r[0];
          tx_sh_r  <= {1'b0, tx_sh_r[7:1]};
          tx_par_r <= tx_par_r ^ tx_sh_r[0];
          tx_n_r   <= (tx_ph_r == PH_DATA) ? tx_n_r + 3'h1 : 3'h0;
        end else if (tx_q == PH_ADDR) begin
          txd_r    <= ctl_r.tx_addr;
          tx_par_r <= tx_par_r ^ ctl_r.tx_addr;
        end else if (tx_q == PH_PAR) begin
          txd_r <= tx_par_r;
        end else begin
          txd_r <= 1'b1;
        end
      end
    end
  end

  assign s_axi_awready  = awready_r;
  assign s_axi_wready   = wready_r;
  assign s_axi_bvalid   = bvalid_r;
  assign s_axi_bresp    = bresp_r;
  assign s_axi_arready  = arready_r;
  assign s_axi_rvalid   = rvalid_r;
  assign s_axi_rdata    = rdata_r;
  assign s_axi_rresp    = rresp_r;
  assign serial_tx_line = txd_r;
  assign irq            = irq_r;

endmodule : uap_top
`default_nettype wire

// File: uap_top_bench.sv
// Purpose: self-checking bench for the serial port register block
// Assumes: divider of 4 keeps frames short
// Notes:   long synch overflow is not exercised, it needs ~500k cycles
`timescale 1ns/10ps
`default_nettype none
module uap_top_bench;
  import uap_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr, d;
  logic [31:0] wdata;
  logic [1:0]  r;
  logic [15:0] bit_cyc;
  logic [3:0]  nbits;
  wire logic        awready, wready, bvalid, arready, rvalid, rx, tx, irq;
  wire logic [1:0]  bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [7:0]  got, got_n;
  int          failures, checks_done;
  uap_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .serial_rx_line(rx), .serial_tx_line(tx),
    .irq(irq));
  uap_peer u_peer (.clk(aclk), .tx(tx), .bit_cyc(bit_cyc), .nbits(nbits),
    .rx(rx), .got(got), .got_n(got_n));
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    awaddr <= a;
    wdata <= {24'h0, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata[7:0];
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    rd(a);
    chk(d, e);
  endtask : rchk
  task automatic wait_got(input logic [7:0] n);
    int k;
    k = 0;
    while (got_n !== n && k < 20000) begin
      @(posedge aclk);
      k++;
    end
    if (k == 20000) begin
      failures++;
      $display("unexpected at %0t: no frame from the peer", $time);
    end
  endtask : wait_got
  task automatic t_reset;
    for (int a = 0; a < 48; a += 4) begin
      rchk(a[7:0], (a == 40) ? 8'h02 : 8'h00);
    end
    chk({7'h0, irq}, 8'h00);
    $display("test reset values done");
  endtask : t_reset
  task automatic t_divider;
    wr(OFS_BRLO, 8'h04);
    wr(OFS_BRHI, 8'h01);
    rchk(OFS_BRHI, 8'h01);
    bit_cyc = 16'd260;
    wr(OFS_TXBUF, 8'hA5);
    wait_got(got_n + 8'h01);
    chk(got, 8'hA5);
    // slow stop bit still running; a write now would change the divider mid-frame
    repeat (200) @(posedge aclk);
    wr(OFS_BRHI, 8'h00);
    bit_cyc = 16'd4;
    $display("test divider done");
  endtask : t_divider
  task automatic t_tx;
    logic [7:0] n;
    n = got_n + 8'h02;
    wr(OFS_IE, 8'h02);
    repeat (2) @(posedge aclk);
    chk({7'h0, irq}, 8'h01);
    wr(OFS_TXBUF, 8'h3C);
    wr(OFS_TXBUF, 8'hC3);
    rchk(OFS_IFG, 8'h00);
    chk({7'h0, irq}, 8'h00);
    rchk(OFS_STAT, 8'h01);
    wait_got(n);
    chk(got, 8'hC3);
    repeat (8) @(posedge aclk);
    rchk(OFS_IFG, 8'h02);
    rchk(OFS_STAT, 8'h00);
    wr(OFS_IE, 8'h00);
    $display("test transmit done");
  endtask : t_tx
  task automatic t_seven;
    wr(OFS_CTL, 8'h01);
    nbits = 4'd7;
    wr(OFS_TXBUF, 8'hFF);
    rchk(OFS_TXBUF, 8'h7F);
    wait_got(got_n + 8'h01);
    chk(got, 8'h7F);
    u_peer.send(8'hD5, 1'b1);
    rchk(OFS_RXBUF, 8'h55);
    wr(OFS_CTL, 8'h00);
    nbits = 4'd8;
    $display("test seven bit done");
  endtask : t_seven
  task automatic t_rx;
    wr(OFS_CTL, 8'h08);
    repeat (48) @(posedge aclk);
    u_peer.send(8'h3C, 1'b1);
    rchk(OFS_IFG, 8'h03);
    rchk(OFS_STAT, 8'h02);
    rchk(OFS_RXBUF, 8'h3C);
    rchk(OFS_STAT, 8'h00);
    rchk(OFS_IFG, 8'h02);
    wr(OFS_CTL, 8'h00);
    u_peer.send(8'h11, 1'b1);
    u_peer.send(8'h22, 1'b0);
    rchk(OFS_STAT, 8'h64);
    rd(OFS_RXBUF);
    rchk(OFS_STAT, 8'h00);
    $display("test receive done");
  endtask : t_rx
  task automatic t_autobaud;
    for (int i = 0; i < 4; i++) begin
      wr(OFS_ABCTL, {2'b11, i[1:0], 4'hE});
      rchk(OFS_ABCTL, {2'b00, i[1:0], 4'hC});
    end
    wr(OFS_ABCTL, 8'h00);
    rchk(OFS_ABCTL, 8'h00);
    u_peer.low(96);
    rchk(OFS_ABCTL, 8'h00);
    rd(OFS_RXBUF);
    wr(OFS_STAT, 8'h00);
    wr(OFS_ABCTL, 8'h01);
    u_peer.low(96);
    rchk(OFS_ABCTL, 8'h05);
    // the cut frame ends with a framing error before break is seen
    rchk(OFS_STAT, 8'h4C);
    rd(OFS_RXBUF);
    rchk(OFS_STAT, 8'h08);
    bit_cyc = 16'd8;
    u_peer.send(8'h55, 1'b1);
    rchk(OFS_BRLO, 8'h08);
    $display("test auto baud done");
  endtask : t_autobaud
  task automatic t_unmapped;
    rd(8'h30);
    chk({r, d[5:0]}, 8'h80);
    wr(8'h30, 8'h5A);
    chk({6'h0, r}, 8'h02);
    $display("test unmapped done");
  endtask : t_unmapped
  task automatic end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim
  // the longest frames need about 3000 cycles; the rest is short
  initial begin
    repeat (40000) @(posedge aclk);
    failures++;
    $display("unexpected at %0t: run timed out", $time);
    end_sim();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    bit_cyc = 16'd4;
    nbits = 4'd8;
    failures = 0;
    checks_done = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset();
    t_divider();
    t_tx();
    t_seven();
    t_rx();
    t_unmapped();
    t_autobaud();
    end_sim();
  end
endmodule : uap_top_bench
bind uap_top uap_checker #(.ADDR_W(ADDR_W)) u_chk (.aclk(aclk),
  .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .serial_rx_line(serial_rx_line), .serial_tx_line(serial_tx_line),
  .irq(irq));
`default_nettype wire
